// File: dcim_consts.svh
`ifndef DCIM_CONSTS_SVH
`define DCIM_CONSTS_SVH

// clock and timing
`define DCIM_CLK_HZ          40000000
`define DCIM_TICK_MS         1
`define DCIM_TICK_CYCLES     (`DCIM_CLK_HZ / 1000 * `DCIM_TICK_MS)
`define DCIM_BLINK_HZ        1
`define DCIM_BLINK_HALF_MS   (1000 / (2 * `DCIM_BLINK_HZ))
`define DCIM_SEQ_ERR_MAX_MS  100

// register byte addresses
`define DCIM_ADDR_CTRL       12'h000
`define DCIM_ADDR_SYNC_TIME  12'h004
`define DCIM_ADDR_STATUS     12'h008
`define DCIM_ADDR_IRQ_STAT   12'h00C
`define DCIM_ADDR_IRQ_MASK   12'h010

// control fields
`define DCIM_CTRL_MODE_BIT   0
`define DCIM_CTRL_SEQREP_BIT 1

// status fields
`define DCIM_ST_LOGIC_BIT    0
`define DCIM_ST_SYNCERR_BIT  1
`define DCIM_ST_SEQERR_BIT   2
`define DCIM_ST_SEEN_BIT     3
`define DCIM_ST_STATE_LSB    4
`define DCIM_ST_CHA_BIT      8
`define DCIM_ST_CHB_BIT      9
`define DCIM_ST_TIMER_LSB    16

// interrupt fields
`define DCIM_IRQ_SYNC_BIT    0
`define DCIM_IRQ_SEQ_BIT     1

// reset values
`define DCIM_CTRL_RST        2'h2
`define DCIM_SYNC_TIME_RST   16'h0000
`define DCIM_IRQ_MASK_RST    2'h0

`endif

// File: dcim_monitor.sv
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "dcim_consts.svh"

module dcim_monitor #(
    parameter int unsigned TICK_CYCLES = `DCIM_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // sensor channels
    input  wire logic        CH_A_I,
    input  wire logic        CH_B_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // logic program input and indicators
    output logic             LOGIC_IN_O,
    output logic             MODULE_STATUS_RED_O,
    output logic             INPUT_LED_A_O,
    output logic             INPUT_LED_B_O,
    // interrupt
    output logic             IRQ_O
);

    // configuration and status
    logic                  mode_disc_q;    // 1: discrepant evaluation
    logic                  seq_report_q;   // 1: newer revision behaviour
    dcim_pkg::dcim_ms_t    sync_time_q;    // synchronous time in ms
    logic [1:0]            irq_stat_q;     // sticky events
    logic [1:0]            irq_mask_q;     // event enables

    // evaluation
    dcim_pkg::dcim_state_e state_q;        // evaluation state
    dcim_pkg::dcim_state_e state_d;
    dcim_pkg::dcim_pair_e  pair;           // class of the channel pair
    dcim_pkg::dcim_ms_t    timer_q;        // synchronous time timer
    logic                  seen_off_q;     // inactive seen since active
    logic                  sync_err_q;     // timeout flag
    logic                  seq_err_q;      // sequence error flag
    logic                  expired;        // timer at or past limit
    logic                  ev_sync;        // timeout event this cycle
    logic                  ev_seq;         // sequence event this cycle

    // timebase and blink
    logic                  tick_ms;        // 1 ms enable
    logic [9:0]            blink_cnt_q;    // ms within half period
    logic                  blink_q;        // blink phase

    // bus decode
    logic                  setup;          // setup phase
    logic                  wr_en;          // write completes
    logic                  addr_ok;        // mapped address
    logic [31:0]           rd_mux;         // read value

    // ms timebase
    dcim_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .tick_o  (tick_ms)
    );

    // classify the channel pair
    always_comb begin
        if (!mode_disc_q) begin
            if (CH_A_I != CH_B_I) begin
                pair = dcim_pkg::DCIM_PAIR_DISC;
            end else if (CH_A_I) begin
                pair = dcim_pkg::DCIM_PAIR_ON;
            end else begin
                pair = dcim_pkg::DCIM_PAIR_OFF;
            end
        end else begin
            if (CH_A_I == CH_B_I) begin
                pair = dcim_pkg::DCIM_PAIR_DISC;
            end else if (CH_A_I) begin
                pair = dcim_pkg::DCIM_PAIR_ON;
            end else begin
                pair = dcim_pkg::DCIM_PAIR_OFF;
            end
        end
    end

    // timeout compare every cycle, never with zero limit
    assign expired = (sync_time_q != 16'h0000) && (timer_q >= sync_time_q);

    // next evaluation state
    always_comb begin
        state_d = state_q;
        ev_sync = 1'b0;
        ev_seq  = 1'b0;
        if (state_q == dcim_pkg::DCIM_ERROR) begin
            // leave error only through inactive
            if (pair == dcim_pkg::DCIM_PAIR_OFF) begin
                state_d = dcim_pkg::DCIM_INACTIVE;
            end
        end else if (expired) begin
            // timeout wins whatever the channels show
            state_d = dcim_pkg::DCIM_ERROR;
            ev_sync = 1'b1;
        end else begin
            unique case (pair)
                dcim_pkg::DCIM_PAIR_OFF: begin
                    state_d = dcim_pkg::DCIM_INACTIVE;
                end
                dcim_pkg::DCIM_PAIR_ON: begin
                    if (state_q == dcim_pkg::DCIM_ACTIVE || seen_off_q) begin
                        state_d = dcim_pkg::DCIM_ACTIVE;
                    end else if (seq_report_q) begin
                        // wrong order, reported at once
                        state_d = dcim_pkg::DCIM_ERROR;
                        ev_seq  = 1'b1;
                    end else begin
                        // older behaviour: silent, output stays low
                        state_d = dcim_pkg::DCIM_DISCREPANT;
                    end
                end
                dcim_pkg::DCIM_PAIR_DISC: begin
                    state_d = dcim_pkg::DCIM_DISCREPANT;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // evaluation state register
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_q <= dcim_pkg::DCIM_INACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // inactive-seen memory for the order check
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            seen_off_q <= 1'b0;
        end else if (state_d == dcim_pkg::DCIM_INACTIVE) begin
            seen_off_q <= 1'b1;
        end else if (state_d == dcim_pkg::DCIM_ACTIVE) begin
            seen_off_q <= 1'b0;
        end
    end

    // synchronous time timer
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            timer_q <= 16'h0000;
        end else if (sync_time_q == 16'h0000) begin
            // checking off: timer never starts
            timer_q <= 16'h0000;
        end else if (state_d != dcim_pkg::DCIM_DISCREPANT) begin
            // held at zero outside discrepant, frozen in error
            if (state_d != dcim_pkg::DCIM_ERROR) begin
                timer_q <= 16'h0000;
            end
        end else if (state_q != dcim_pkg::DCIM_DISCREPANT) begin
            // first change into discrepant restarts it
            timer_q <= 16'h0000;
        end else if (tick_ms && timer_q != 16'hFFFF) begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    // timeout flag
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync_err_q <= 1'b0;
        end else if (ev_sync) begin
            sync_err_q <= 1'b1;
        end else if (state_d == dcim_pkg::DCIM_INACTIVE && state_q == dcim_pkg::DCIM_ERROR) begin
            sync_err_q <= 1'b0;
        end else if (state_d == dcim_pkg::DCIM_ACTIVE && !mode_disc_q) begin
            sync_err_q <= 1'b0;
        end else if (mode_disc_q && CH_A_I && CH_B_I && state_d == dcim_pkg::DCIM_DISCREPANT) begin
            sync_err_q <= 1'b0;
        end
    end

    // sequence error flag
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            seq_err_q <= 1'b0;
        end else if (ev_seq) begin
            seq_err_q <= 1'b1;
        end else if (state_d == dcim_pkg::DCIM_INACTIVE) begin
            seq_err_q <= 1'b0;
        end
    end

    // logical input, low in every state but active
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LOGIC_IN_O <= 1'b0;
        end else begin
            LOGIC_IN_O <= (state_d == dcim_pkg::DCIM_ACTIVE);
        end
    end

    // 1 hz blink phase, restarted when error begins
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            blink_cnt_q <= 10'h000;
            blink_q     <= 1'b0;
        end else if (state_q != dcim_pkg::DCIM_ERROR) begin
            blink_cnt_q <= 10'h000;
            blink_q     <= 1'b1;
        end else if (tick_ms) begin
            if (blink_cnt_q >= 10'(`DCIM_BLINK_HALF_MS - 1)) begin
                blink_cnt_q <= 10'h000;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 10'h001;
            end
        end
    end

    // indicators: blink in error, else green follows channels
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MODULE_STATUS_RED_O <= 1'b0;
            INPUT_LED_A_O       <= 1'b0;
            INPUT_LED_B_O       <= 1'b0;
        end else if (state_q == dcim_pkg::DCIM_ERROR) begin
            MODULE_STATUS_RED_O <= blink_q;
            INPUT_LED_A_O       <= blink_q;
            INPUT_LED_B_O       <= blink_q;
        end else begin
            MODULE_STATUS_RED_O <= 1'b0;
            INPUT_LED_A_O       <= CH_A_I;
            INPUT_LED_B_O       <= CH_B_I;
        end
    end

    // bus phases
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;

    // read decode
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        unique case (PADDR_I)
            `DCIM_ADDR_CTRL: begin
                rd_mux[`DCIM_CTRL_MODE_BIT]   = mode_disc_q;
                rd_mux[`DCIM_CTRL_SEQREP_BIT] = seq_report_q;
            end
            `DCIM_ADDR_SYNC_TIME: begin
                rd_mux[15:0] = sync_time_q;
            end
            `DCIM_ADDR_STATUS: begin
                rd_mux[`DCIM_ST_LOGIC_BIT]                       = LOGIC_IN_O;
                rd_mux[`DCIM_ST_SYNCERR_BIT]                     = sync_err_q;
                rd_mux[`DCIM_ST_SEQERR_BIT]                      = seq_err_q;
                rd_mux[`DCIM_ST_SEEN_BIT]                        = seen_off_q;
                rd_mux[`DCIM_ST_STATE_LSB +: 4]                  = state_q;
                rd_mux[`DCIM_ST_CHA_BIT]                         = CH_A_I;
                rd_mux[`DCIM_ST_CHB_BIT]                         = CH_B_I;
                rd_mux[`DCIM_ST_TIMER_LSB +: 16]                 = timer_q;
            end
            `DCIM_ADDR_IRQ_STAT: begin
                rd_mux[1:0] = irq_stat_q;
            end
            `DCIM_ADDR_IRQ_MASK: begin
                rd_mux[1:0] = irq_mask_q;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // apb answer: ready for exactly one access cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end else if (setup) begin
            PREADY_O  <= 1'b1;
            PSLVERR_O <= !addr_ok;
            PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
        end else begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
    end

    // configuration writes
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_disc_q  <= 1'(`DCIM_CTRL_RST >> `DCIM_CTRL_MODE_BIT);
            seq_report_q <= 1'(`DCIM_CTRL_RST >> `DCIM_CTRL_SEQREP_BIT);
            sync_time_q  <= `DCIM_SYNC_TIME_RST;
            irq_mask_q   <= `DCIM_IRQ_MASK_RST;
        end else if (wr_en) begin
            unique case (PADDR_I)
                `DCIM_ADDR_CTRL: begin
                    mode_disc_q  <= PWDATA_I[`DCIM_CTRL_MODE_BIT];
                    seq_report_q <= PWDATA_I[`DCIM_CTRL_SEQREP_BIT];
                end
                `DCIM_ADDR_SYNC_TIME: begin
                    sync_time_q <= PWDATA_I[15:0];
                end
                `DCIM_ADDR_IRQ_MASK: begin
                    irq_mask_q <= PWDATA_I[1:0];
                end
                default: begin
                    irq_mask_q <= irq_mask_q;
                end
            endcase
        end
    end

    // sticky events, write one to clear, set wins
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q[`DCIM_IRQ_SYNC_BIT] <= ev_sync ||
                (irq_stat_q[`DCIM_IRQ_SYNC_BIT] &&
                 !(wr_en && PADDR_I == `DCIM_ADDR_IRQ_STAT && PWDATA_I[`DCIM_IRQ_SYNC_BIT]));
            irq_stat_q[`DCIM_IRQ_SEQ_BIT]  <= ev_seq ||
                (irq_stat_q[`DCIM_IRQ_SEQ_BIT] &&
                 !(wr_en && PADDR_I == `DCIM_ADDR_IRQ_STAT && PWDATA_I[`DCIM_IRQ_SEQ_BIT]));
        end
    end

    // level interrupt
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(irq_stat_q & irq_mask_q);
        end
    end

endmodule : dcim_monitor

// File: dcim_monitor_sva.sv
`timescale 1ns/10ps

// port-level checks on the monitor
module dcim_monitor_sva (
    // clock and reset
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    // channels and bus
    input wire logic        CH_A_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    // indicators
    input wire logic        LOGIC_IN_O,
    input wire logic        MODULE_STATUS_RED_O,
    input wire logic        INPUT_LED_A_O,
    input wire logic        INPUT_LED_B_O,
    input wire logic        IRQ_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // bus setup cycle
    sequence setup_s;
        PSEL_I && !PENABLE_I;
    endsequence
    // access cycle answered
    sequence answer_s;
        PREADY_O && PSEL_I && PENABLE_I;
    endsequence

    ready_next_a: assert property (setup_s |=> answer_s)
        else $error("no ready after setup");
    ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
        else $error("ready without setup");
    err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
        else $error("slave error without ready");
    wr_zero_a: assert property (PREADY_O && PWRITE_I |-> PRDATA_O == 32'h0)
        else $error("read data not zero on write");
    logic_cause_a: assert property (LOGIC_IN_O |-> $past(CH_A_I))
        else $error("logical input high with channel a low");
    err_low_a: assert property (MODULE_STATUS_RED_O |-> !LOGIC_IN_O)
        else $error("logical input high in error");
    err_leds_a: assert property (MODULE_STATUS_RED_O |-> INPUT_LED_A_O && INPUT_LED_B_O)
        else $error("input leds out of phase with red");
    led_copy_a: assert property (INPUT_LED_A_O && !MODULE_STATUS_RED_O |-> $past(CH_A_I))
        else $error("input led a not following channel");
    reset_quiet_a: assert property (disable iff (1'b0)
        !RST_N_I ##1 !RST_N_I |-> !PREADY_O && !LOGIC_IN_O && !IRQ_O && !MODULE_STATUS_RED_O)
        else $error("outputs not quiet in reset");
endmodule : dcim_monitor_sva

// File: dcim_pkg.sv
package dcim_pkg;

    // evaluation state, one-hot
    typedef enum logic [3:0] {
        DCIM_INACTIVE   = 4'h1,
        DCIM_ACTIVE     = 4'h2,
        DCIM_DISCREPANT = 4'h4,
        DCIM_ERROR      = 4'h8
    } dcim_state_e;

    // value of the channel pair alone
    typedef enum logic [2:0] {
        DCIM_PAIR_OFF  = 3'h1,
        DCIM_PAIR_ON   = 3'h2,
        DCIM_PAIR_DISC = 3'h4
    } dcim_pair_e;

    typedef logic [15:0] dcim_ms_t;

endpackage : dcim_pkg

// File: dcim_sensor_model.sv
`timescale 1ns/10ps

// two-channel sensor; channel b may lag
module dcim_sensor_model #(
    parameter int LAG = 6
) (
    // clock and mode
    input  wire logic clk_i,
    input  wire logic slow_i,
    // requested levels
    input  wire logic a_req_i,
    input  wire logic b_req_i,
    // sensor channels
    output logic      ch_a_o,
    output logic      ch_b_o
);
    logic [LAG-1:0] b_pipe_q = '0; // delay line for channel b

    // switch-on and switch-off delay of the slow channel
    always @(posedge clk_i) begin
        b_pipe_q <= {b_pipe_q[LAG-2:0], b_req_i};
    end

    assign ch_a_o = a_req_i;
    assign ch_b_o = slow_i ? b_pipe_q[LAG-1] : b_req_i;
endmodule : dcim_sensor_model

// File: dcim_tb.sv
`timescale 1ns/10ps
`include "dcim_consts.svh"

module testbench;
    localparam int TICK = 4; // ms tick shortened
    // clock, reset, bus and sensor requests
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        req_a = 1'b0;
    logic        req_b = 1'b0;
    logic        slow = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, ch_a, ch_b, lin, red, led_a, led_b, irq;
    int          fails = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [31:0] v;
    logic        e;
    logic [3:0]  es;
    int          n;

    always #12.5 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    dcim_sensor_model #(.LAG(6)) snr_u (.clk_i(clk), .slow_i(slow), .a_req_i(req_a), .b_req_i(req_b),
        .ch_a_o(ch_a), .ch_b_o(ch_b));
    dcim_monitor #(.TICK_CYCLES(TICK)) dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CH_A_I(ch_a), .CH_B_I(ch_b),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LOGIC_IN_O(lin),
        .MODULE_STATUS_RED_O(red), .INPUT_LED_A_O(led_a), .INPUT_LED_B_O(led_b), .IRQ_O(irq));

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer, waits for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait for ready; if ready never comes, only the hang guard ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns the strobes at once
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v, e);
        chk({31'h0, e}, 32'h0, "write error");
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0, v, e);
        chk(v & m, x, s);
    endtask : rd_chk

    task automatic pair(input logic a, input logic b, input int c);
        req_a <= a;
        req_b <= b;
        repeat (c) @(posedge clk);
    endtask : pair

    // cycles until the red indicator changes
    task automatic to_change(output int c);
        logic r;
        r = red;
        c = 0;
        while (red === r && c < 2100) begin
            @(posedge clk);
            c++;
        end
    endtask : to_change

    // expected state of a pair in a mode
    function automatic logic [3:0] exp_state(input logic m, input logic a, input logic b);
        if ((a ^ b) == m) return a ? dcim_pkg::DCIM_ACTIVE : dcim_pkg::DCIM_INACTIVE;
        return dcim_pkg::DCIM_DISCREPANT;
    endfunction : exp_state

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // reset values, read-only status, unmapped place
        rd_chk(`DCIM_ADDR_CTRL, 32'hFFFFFFFF, 32'h2, "ctrl");
        rd_chk(`DCIM_ADDR_SYNC_TIME, 32'hFFFFFFFF, 32'h0, "sync");
        rd_chk(`DCIM_ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "mask");
        wr(`DCIM_ADDR_STATUS, 32'hFFFFFFFF);
        rd_chk(`DCIM_ADDR_STATUS, 32'hFFFFFFF7, 32'h10, "status");
        apb(1'b0, 12'h014, 32'h0, v, e);
        chk(v, 32'h0, "unmapped data");
        chk({31'h0, e}, 32'h1, "unmapped error");
        $display("test registers done");
        // truth table of both modes
        for (int m = 0; m < 2; m++) begin
            wr(`DCIM_ADDR_CTRL, {30'h0, 1'b1, m[0]});
            for (int p = 0; p < 4; p++) begin
                pair(1'b0, m[0], 4);
                pair(p[1], p[0], 4);
                es = exp_state(m[0], p[1], p[0]);
                rd_chk(`DCIM_ADDR_STATUS, 32'hF1, {24'h0, es, 3'h0, es == dcim_pkg::DCIM_ACTIVE}, "class");
                chk({31'h0, lin}, {31'h0, es == dcim_pkg::DCIM_ACTIVE}, "logic pin");
            end
        end
        $display("test truth table done");
        // sequence fault, newer revision
        wr(`DCIM_ADDR_CTRL, 32'h2);
        wr(`DCIM_ADDR_IRQ_MASK, 32'h3);
        pair(1'b0, 1'b0, 4);
        pair(1'b1, 1'b1, 4);
        pair(1'b1, 1'b0, 4);
        pair(1'b1, 1'b1, 4);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF7, {24'h0, dcim_pkg::DCIM_ERROR, 4'h4}, "seq error");
        rd_chk(`DCIM_ADDR_IRQ_STAT, 32'h3, 32'h2, "seq event");
        chk({31'h0, irq}, 32'h1, "irq pin");
        to_change(n);
        to_change(n);
        chk(n, 500 * TICK, "blink half");
        chk({led_a, led_b, lin}, {red, red, 1'b0}, "error leds");
        pair(1'b0, 1'b0, 4);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF6, {24'h0, dcim_pkg::DCIM_INACTIVE, 4'h0}, "cleared");
        wr(`DCIM_ADDR_IRQ_STAT, 32'h3);
        rd_chk(`DCIM_ADDR_IRQ_STAT, 32'h3, 32'h0, "irq clear");
        chk({31'h0, irq}, 32'h0, "irq low");
        // older revision keeps quiet
        wr(`DCIM_ADDR_CTRL, 32'h0);
        pair(1'b1, 1'b1, 4);
        pair(1'b1, 1'b0, 4);
        pair(1'b1, 1'b1, 4);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF5, {24'h0, dcim_pkg::DCIM_DISCREPANT, 4'h0}, "old seq");
        pair(1'b0, 1'b0, 4);
        $display("test sequence done");
        // synchronous-time timeout
        wr(`DCIM_ADDR_CTRL, 32'h2);
        wr(`DCIM_ADDR_SYNC_TIME, 32'h8);
        pair(1'b1, 1'b0, 20);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF3, {24'h0, dcim_pkg::DCIM_DISCREPANT, 4'h0}, "before limit");
        pair(1'b1, 1'b0, 20);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF3, {24'h0, dcim_pkg::DCIM_ERROR, 4'h2}, "timeout");
        rd_chk(`DCIM_ADDR_IRQ_STAT, 32'h3, 32'h1, "timeout event");
        pair(1'b1, 1'b1, 4);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF3, {24'h0, dcim_pkg::DCIM_ERROR, 4'h2}, "no active");
        pair(1'b0, 1'b0, 4);
        rd_chk(`DCIM_ADDR_STATUS, 32'hF3, {24'h0, dcim_pkg::DCIM_INACTIVE, 4'h0}, "timeout gone");
        // slow second channel within the window
        slow <= 1'b1;
        pair(1'b1, 1'b1, 20);
        rd_chk(`DCIM_ADDR_STATUS, 32'hFFFF00F3, {24'h0, dcim_pkg::DCIM_ACTIVE, 4'h1}, "late on");
        pair(1'b0, 1'b0, 20);
        slow <= 1'b0;
        // zero synchronous time never times out
        wr(`DCIM_ADDR_SYNC_TIME, 32'h0);
        pair(1'b0, 1'b1, 60);
        rd_chk(`DCIM_ADDR_STATUS, 32'hFFFF00F3, {24'h0, dcim_pkg::DCIM_DISCREPANT, 4'h0}, "no timer");
        pair(1'b0, 1'b0, 4);
        $display("test timeout done");
        report_and_stop();
    end
endmodule : testbench

bind dcim_monitor dcim_monitor_sva chk_u (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CH_A_I(CH_A_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .LOGIC_IN_O(LOGIC_IN_O), .MODULE_STATUS_RED_O(MODULE_STATUS_RED_O),
    .INPUT_LED_A_O(INPUT_LED_A_O), .INPUT_LED_B_O(INPUT_LED_B_O), .IRQ_O(IRQ_O));

// File: dcim_tick_div.sv
`timescale 1ns/10ps
`include "dcim_consts.svh"

// one-cycle enable every CYCLES clock cycles
module dcim_tick_div #(
    parameter int unsigned CYCLES = `DCIM_TICK_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // tick out
    output logic      tick_o
);

    logic [31:0] cnt_q;  // cycles since last tick

    // free-running divider
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_q >= CYCLES - 1) begin
            cnt_q  <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_o <= 1'b0;
        end
    end

endmodule : dcim_tick_div
